// ---- rtl/move_and_nop_instr_decode.sv ----
// Execute logic for register copy, accumulator store, config load and idle
// How it works
// - A word with top bits 00 1000 is a register copy with bit 7 as destination and a 7-bit address.
// - A copy writes the read value to the accumulator when bit 7 is 0, else back to the register.
// - A copy sets the zero flag if the moved value is zero and clears it otherwise.
// - A word 00 0000 1 plus address stores the accumulator into that register, flags untouched.
// - The word 00 0000 0110 0010 copies the accumulator into the timer config register.
// - The timer config register also sits in file space and can be read and written there.
`timescale 1ns/1ps
`default_nettype none
module move_and_nop_instr_decode
   import move_decode_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                instr_valid,
   input  wire logic [INSTR_W-1:0]  instr,
   input  wire logic [DATA_W-1:0]   file_rdata,
   output logic      [ADDR_W-1:0]   file_addr,
   output logic                     file_we,
   output logic      [DATA_W-1:0]   file_wdata,
   output logic      [DATA_W-1:0]   acc,
   output logic      [DATA_W-1:0]   timer_cfg,
   output logic                     result_null_flag,
   output logic                     unknown_instr
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta;
   logic rst_sync_n;

   // Two-stage release of the asynchronous reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   op_decode_if dec ();

   op_decoder u_dec (
      .instr (instr),
      .dec   (dec)
   );

   // ----------------------------------------
   // Read path and write port
   // ----------------------------------------
   logic              cfg_hit;
   logic [DATA_W-1:0] read_value;

   // config register read in file space
   assign cfg_hit    = (dec.addr == CFG_ADDR);
   assign read_value = cfg_hit ? timer_cfg : file_rdata;
   assign file_addr  = dec.addr;

   // Write to the external file, except for the config location
   always_comb begin
      file_we    = 1'b0;
      file_wdata = DATA_ZERO;
      if (instr_valid && !cfg_hit) begin
         if (dec.kind == OP_COPY && dec.dest_file) begin
            file_we    = 1'b1;
            file_wdata = read_value;
         end else if (dec.kind == OP_STORE) begin
            file_we    = 1'b1;
            file_wdata = acc;
         end
      end
   end

   // ----------------------------------------
   // Architectural state
   // ----------------------------------------
   logic [DATA_W-1:0] next_acc;
   logic [DATA_W-1:0] next_timer_cfg;
   logic              next_result_null_flag;
   logic              next_unknown_instr;

   // Next values of accumulator, config register and zero flag
   always_comb begin
      next_acc              = acc;
      next_timer_cfg        = timer_cfg;
      next_result_null_flag = result_null_flag;
      next_unknown_instr    = 1'b0;
      if (instr_valid) begin
         unique case (dec.kind)
            OP_COPY: begin
               if (!dec.dest_file) begin
                  next_acc = read_value;
               end else if (cfg_hit) begin
                  next_timer_cfg = read_value;
               end
               next_result_null_flag = (read_value == DATA_ZERO);
            end
            OP_STORE: begin
               // config register written in file space
               if (cfg_hit) begin
                  next_timer_cfg = acc;
               end
            end
            OP_CFG: begin
               next_timer_cfg = acc;
            end
            OP_IDLE: begin
               next_acc = acc;
            end
            OP_OTHER: begin
               next_unknown_instr = 1'b1;
            end
         endcase
      end
   end

   // Register the state
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         acc              <= ACC_RESET;
         timer_cfg        <= CFG_RESET;
         result_null_flag <= 1'b0;
         unknown_instr    <= 1'b0;
      end else begin
         acc              <= next_acc;
         timer_cfg        <= next_timer_cfg;
         result_null_flag <= next_result_null_flag;
         unknown_instr    <= next_unknown_instr;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_copy_acc;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_COPY && !dec.dest_file
         |=> acc == $past(read_value);
   endproperty
   a_copy_acc : assert property (p_copy_acc)
      else $error("copy to accumulator lost value");

   property p_copy_zero;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_COPY
         |=> result_null_flag == ($past(read_value) == DATA_ZERO);
   endproperty
   a_copy_zero : assert property (p_copy_zero)
      else $error("zero flag wrong after copy");

   property p_copy_back;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_COPY && dec.dest_file && !cfg_hit
         |-> file_we && file_wdata == file_rdata ##1 $stable(acc);
   endproperty
   a_copy_back : assert property (p_copy_back)
      else $error("copy back write missing");

   property p_store_flags;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_STORE
         |=> $stable(result_null_flag) && $stable(acc);
   endproperty
   a_store_flags : assert property (p_store_flags)
      else $error("store changed flag or accumulator");

   property p_store_write;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_STORE && !cfg_hit |-> file_we && file_wdata == acc;
   endproperty
   a_store_write : assert property (p_store_write)
      else $error("store did not write accumulator");

   property p_cfg_load;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && instr == WORD_CFG_LOAD
         |=> timer_cfg == $past(acc) && $stable(result_null_flag);
   endproperty
   a_cfg_load : assert property (p_cfg_load)
      else $error("config load failed");

   property p_cfg_file;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_STORE && cfg_hit
         |-> !file_we ##1 timer_cfg == $past(acc);
   endproperty
   a_cfg_file : assert property (p_cfg_file)
      else $error("config register not mapped in file space");

   property p_idle;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && (instr & IDLE_MASK) == IDLE_MATCH
         |-> !file_we ##1 ($stable(acc) && $stable(timer_cfg) && $stable(result_null_flag));
   endproperty
   a_idle : assert property (p_idle)
      else $error("idle instruction changed state");

   property p_copy_cfg;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_COPY && !dec.dest_file && cfg_hit
         |-> !file_we ##1 acc == $past(timer_cfg);
   endproperty
   a_copy_cfg : assert property (p_copy_cfg)
      else $error("copy from config location did not read config register");

   property p_unknown;
      @(posedge clk) disable iff (!rst_sync_n)
      instr_valid && dec.kind == OP_OTHER
         |-> !file_we ##1 (unknown_instr && $stable(acc) && $stable(timer_cfg));
   endproperty
   a_unknown : assert property (p_unknown)
      else $error("word outside the group not flagged or changed state");

endmodule : move_and_nop_instr_decode
`default_nettype wire

// ---- rtl/move_decode_pkg.sv ----
// Constants and types for the move and idle instruction decoder
package move_decode_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int INSTR_W = 14;
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 7;

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [5:0]  OPC_COPY_REG    = 6'h08;   // 00 1000
   localparam logic [6:0]  OPC_STORE_ACC   = 7'h01;   // 00 0000 1
   localparam logic [13:0] WORD_CFG_LOAD   = 14'h0062;
   localparam logic [13:0] IDLE_MASK       = 14'h3F9F; // Ignores bits 6:5
   localparam logic [13:0] IDLE_MATCH      = 14'h0000;
   localparam int          DEST_BIT        = 7;

   // ----------------------------------------
   // Reset values and file map
   // ----------------------------------------
   localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] CFG_RESET  = 8'hFF;
   localparam logic [ADDR_W-1:0] CFG_ADDR   = 7'h01;
   localparam logic [ADDR_W-1:0] ADDR_ZERO  = 7'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

   typedef enum logic [2:0] {
      OP_IDLE,
      OP_COPY,
      OP_STORE,
      OP_CFG,
      OP_OTHER
   } op_kind_t;

endpackage : move_decode_pkg

// ---- rtl/op_decode_if.sv ----
// Decoded instruction fields passed from the decoder to the execute logic
`timescale 1ns/1ps
`default_nettype none
interface op_decode_if;
   import move_decode_pkg::*;
   op_kind_t          kind;
   logic [ADDR_W-1:0] addr;
   logic              dest_file;
   modport decoder (output kind, output addr, output dest_file);
   modport user    (input kind, input addr, input dest_file);
endinterface : op_decode_if
`default_nettype wire

// ---- rtl/op_decoder.sv ----
// Pure combinational instruction word decoder
`timescale 1ns/1ps
`default_nettype none
module op_decoder
   import move_decode_pkg::*;
(
   input  wire logic [INSTR_W-1:0] instr,
   op_decode_if.decoder            dec
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   always_comb begin
      dec.addr      = instr[ADDR_W-1:0];
      dec.dest_file = instr[DEST_BIT];
      if (instr[INSTR_W-1 -: 6] == OPC_COPY_REG) begin
         dec.kind = OP_COPY;
      end else if (instr[INSTR_W-1 -: 7] == OPC_STORE_ACC) begin
         dec.kind = OP_STORE;
      end else if (instr == WORD_CFG_LOAD) begin
         dec.kind = OP_CFG;
      end else if ((instr & IDLE_MASK) == IDLE_MATCH) begin
         dec.kind = OP_IDLE;
      end else begin
         dec.kind = OP_OTHER;
      end
   end

endmodule : op_decoder
`default_nettype wire

// ---- tb/move_and_nop_instr_decode_tb.sv ----
// Self-checking bench for the move and idle instruction decoder
`timescale 1ns/1ps
`default_nettype none
module move_and_nop_instr_decode_tb;
   import move_decode_pkg::*;
   logic               clk;
   logic               rstn;
   logic               instr_valid;
   logic [3:0]         pc;
   logic [INSTR_W-1:0] instr;
   logic [DATA_W-1:0]  file_rdata;
   logic [ADDR_W-1:0]  file_addr;
   logic               file_we;
   logic [DATA_W-1:0]  file_wdata;
   logic [DATA_W-1:0]  acc;
   logic [DATA_W-1:0]  timer_cfg;
   logic               result_null_flag;
   logic               unknown_instr;
   logic [DATA_W-1:0]  fmem [128];
   int                 num_errors;
   int                 comparisons;
   int                 cycles;

   prog_mem u_mem (.pc(pc), .word(instr));
   move_and_nop_instr_decode DUT (
      .clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
      .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
      .file_wdata(file_wdata), .acc(acc), .timer_cfg(timer_cfg),
      .result_null_flag(result_null_flag), .unknown_instr(unknown_instr)
   );

   // ----------------------------------------
   // Clock, file registers and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   assign file_rdata = fmem[file_addr];
   always @(posedge clk) begin
      if (file_we) fmem[file_addr] <= file_wdata;
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : check

   // Executes one program word, then lets its results settle
   task automatic step(input logic [3:0] idx);
      @(posedge clk);
      pc <= idx;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask : step

   task automatic test_reset;
      check("acc", acc, 8'h00);
      check("timer_cfg", timer_cfg, 8'hFF);
      check("flag", {7'h00, result_null_flag}, 8'h00);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_copy_store;
      step(4'h0);
      check("acc", acc, 8'h5A);
      check("flag", {7'h00, result_null_flag}, 8'h00);
      step(4'h1);
      check("file 2A", fmem[7'h2A], 8'h5A);
      check("flag", {7'h00, result_null_flag}, 8'h00);
      step(4'h3);
      check("acc", acc, 8'h00);
      check("flag", {7'h00, result_null_flag}, 8'h01);
      $display("test_copy_store done");
   endtask : test_copy_store

   task automatic test_cfg;
      step(4'h2);
      check("timer_cfg", timer_cfg, 8'h00);
      step(4'h0);
      step(4'h2);
      check("timer_cfg", timer_cfg, 8'h5A);
      step(4'h3);
      step(4'h4);
      check("acc", acc, 8'h5A);
      check("flag", {7'h00, result_null_flag}, 8'h00);
      step(4'h3);
      step(4'h5);
      check("timer_cfg", timer_cfg, 8'h00);
      check("file 01", fmem[7'h01], 8'h33);
      check("flag", {7'h00, result_null_flag}, 8'h01);
      $display("test_cfg done");
   endtask : test_cfg

   task automatic test_idle;
      step(4'h0);
      for (int i = 6; i <= 8; i++) begin
         step(4'(i));
         check("acc", acc, 8'h5A);
         check("timer_cfg", timer_cfg, 8'h00);
         check("flag", {7'h00, result_null_flag}, 8'h00);
      end
      $display("test_idle done");
   endtask : test_idle

   task automatic test_zero_probe;
      step(4'h0);
      step(4'h9);
      check("acc", acc, 8'h5A);
      check("file 0B", fmem[7'h0B], 8'h00);
      check("flag", {7'h00, result_null_flag}, 8'h01);
      $display("test_zero_probe done");
   endtask : test_zero_probe

   // Word outside the group pulses the flag for one cycle only
   task automatic test_unknown;
      step(4'hA);
      check("unknown", {7'h00, unknown_instr}, 8'h01);
      check("acc", acc, 8'h5A);
      check("timer_cfg", timer_cfg, 8'h00);
      check("flag", {7'h00, result_null_flag}, 8'h01);
      @(posedge clk);
      #1;
      check("unknown", {7'h00, unknown_instr}, 8'h00);
      $display("test_unknown done");
   endtask : test_unknown

   task automatic test_done;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      instr_valid = 1'b0;
      pc = 4'h0;
      num_errors = 0;
      comparisons = 0;
      cycles = 0;
      foreach (fmem[i]) fmem[i] = 8'h00;
      fmem[7'h06] = 8'h5A;
      fmem[7'h01] = 8'h33;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      test_reset();
      test_copy_store();
      test_cfg();
      test_idle();
      test_zero_probe();
      test_unknown();
      test_done();
   end
endmodule : move_and_nop_instr_decode_tb
`default_nettype wire

// ---- tb/prog_mem.sv ----
// Program memory model that hands out fixed instruction words
`timescale 1ns/1ps
`default_nettype none
module prog_mem
   import move_decode_pkg::*;
(
   input  wire logic [3:0]         pc,
   output logic      [INSTR_W-1:0] word
);
   // Fixed program; slots past the end hold a word outside the group
   always_comb begin
      case (pc)
         4'h0:    word = 14'h0806;
         4'h1:    word = 14'h00AA;
         4'h2:    word = 14'h0062;
         4'h3:    word = 14'h0805;
         4'h4:    word = 14'h0801;
         4'h5:    word = 14'h0081;
         4'h6:    word = 14'h0060;
         4'h7:    word = 14'h0020;
         4'h8:    word = 14'h0000;
         4'h9:    word = 14'h088B;
         default: word = 14'h3FFF;
      endcase
   end
endmodule : prog_mem
`default_nettype wire
